// *** abs_search_engine.sv ***
// address binary search engine: argument latches, compare slices, search control, results word
`timescale 1ns/100ps
`include "abs_params.svh"

module abs_search_engine (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // processor bus
  input wire logic i_unit_select,
  input wire logic i_cpu_write_direction,
  input wire logic i_xcvr_select_0,
  input wire logic i_xcvr_select_1,
  input wire logic i_xcvr_select_2,
  input wire logic [`ABS_AW-1:0] i_cpu_table_address,
  input wire logic [`ABS_DW-1:0] i_cpu_data_bus,
  output logic [`ABS_DW-1:0] o_cpu_data_bus,
  output logic o_cpu_data_bus_oe,
  // search start address
  input wire logic [`ABS_AW-1:0] i_search_address_bus,
  // address table memory
  output logic [`ABS_AW-1:0] o_table_address,
  input wire logic [`ABS_KW-1:0] i_table_data,
  output logic [`ABS_DW-1:0] o_table_wdata,
  output logic [`ABS_LANES-1:0] o_table_lane_we,
  // status
  output logic o_search_done,
  output logic o_probe_select_steer_n
);

  // ****************************************
  // constants and state
  // ****************************************
  localparam logic [`ABS_DIV_W-1:0] DIV_LAST = `ABS_DIV_W'(`ABS_STEER_CYC - 1);
  localparam logic [`ABS_DIV_W-1:0] DIV_ONE = `ABS_DIV_W'(1);
  localparam logic [`ABS_AW-1:0] ADDR_ONE = `ABS_AW'(1);

  // idle, selector on processor, results and strobes clear
  localparam abs_pkg::abs_regs_t RST = '{
    fsm: abs_pkg::ABS_IDLE,
    done: `ABS_DONE_RST,
    steer_n: `ABS_STEER_RST,
    div: '0,
    probe: '0,
    tbl_addr: '0,
    arg: '0,
    match: 1'b0,
    above: 1'b0,
    pend_v: 1'b0,
    pend_wr: 1'b0,
    pend_sel: '0,
    dout: '0,
    doe: 1'b0,
    we: '0,
    wdata: '0
  };

  abs_pkg::abs_regs_t r;
  abs_pkg::abs_regs_t n;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic is_arg_word(input logic [2:0] code);
    return (code >= `ABS_SEL_ARG_LO) && (code <= `ABS_SEL_ARG_HI);
  endfunction : is_arg_word

  function automatic logic is_tbl_word(input logic [2:0] code);
    return code >= `ABS_SEL_TBL_LO;
  endfunction : is_tbl_word

  // only codes with a word to show answer a read
  function automatic logic drives_bus(input logic [2:0] code);
    return is_arg_word(code) || (code == `ABS_SEL_RESULT) || is_tbl_word(code);
  endfunction : drives_bus

  function automatic logic [1:0] lane_of(input logic [2:0] sel);
    logic [2:0] base;
    base = is_tbl_word(sel) ? `ABS_SEL_TBL_LO : `ABS_SEL_ARG_LO;
    return 2'(sel - base);
  endfunction : lane_of

  function automatic logic [`ABS_DW-1:0] word_of(input logic [`ABS_KW-1:0] v, input logic [1:0] lane);
    return v[`ABS_DW * lane +: `ABS_DW];
  endfunction : word_of

  // returns {greater, equal}, the most significant part deciding first
  function automatic logic [1:0] cascade4(input logic [3:0] gt, input logic [3:0] eq);
    logic [1:0] res;
    res = 2'h1;
    for (int k = 3; k >= 0; k = k - 1) begin
      if (res[0] && !eq[k]) begin
        res = {gt[k], 1'b0};
      end
    end
    return res;
  endfunction : cascade4

  // 2:1 table address selector, low steer picks the probe
  function automatic logic [`ABS_AW-1:0] table_pick(input logic steer_n, input logic [`ABS_AW-1:0] cpu_addr,
                                                    input logic [`ABS_AW-1:0] probe_addr);
    return steer_n ? cpu_addr : probe_addr;
  endfunction : table_pick

  // next probe one tree level down, half the current step away, upwards for greater
  function automatic logic [`ABS_AW-1:0] next_probe(input logic [`ABS_AW-1:0] cur, input logic up);
    logic [`ABS_AW-1:0] lsb;
    logic [`ABS_AW-1:0] step;
    lsb = cur & (~cur + ADDR_ONE);
    step = lsb >> 1;
    return up ? cur + step : cur - step;
  endfunction : next_probe

  // ****************************************
  // nibble compare elements
  // ****************************************
  logic [`ABS_NIBS-1:0] nib_gt;
  logic [`ABS_NIBS-1:0] nib_eq;
  logic [`ABS_SLICES-1:0] sl_gt;
  logic [`ABS_SLICES-1:0] sl_eq;
  logic arg_gt;
  logic arg_eq;

  // one element per nibble, its latch shared with the move path
  genvar g;
  generate
    for (g = 0; g < `ABS_NIBS; g = g + 1) begin : g_nib
      assign nib_gt[g] = r.arg[`ABS_NIB_W*g +: `ABS_NIB_W] > i_table_data[`ABS_NIB_W*g +: `ABS_NIB_W];
      assign nib_eq[g] = r.arg[`ABS_NIB_W*g +: `ABS_NIB_W] == i_table_data[`ABS_NIB_W*g +: `ABS_NIB_W];
    end
  endgenerate

  genvar s;
  generate
    for (s = 0; s < `ABS_SLICES; s = s + 1) begin : g_slice
      assign {sl_gt[s], sl_eq[s]} = cascade4(nib_gt[`ABS_SLICE_NIBS*s +: `ABS_SLICE_NIBS],
                                             nib_eq[`ABS_SLICE_NIBS*s +: `ABS_SLICE_NIBS]);
    end
  endgenerate

  // high slice decides first; padding slice always equal
  assign {arg_gt, arg_eq} = cascade4({1'b0, sl_gt}, {1'b1, sl_eq});

  // ****************************************
  // processor decode and results word
  // ****************************************
  logic [2:0] sel;
  logic acc;
  logic acc_wr;
  logic [`ABS_DW-1:0] result_word;
  logic at_bottom;
  logic steer_tick;
  logic start_hit;

  assign sel = {i_xcvr_select_2, i_xcvr_select_1, i_xcvr_select_0};
  // all access blocked while a search runs or the selector is still on probes
  assign acc = i_unit_select && r.done && r.steer_n && (r.fsm == abs_pkg::ABS_IDLE);
  assign acc_wr = acc && i_cpu_write_direction;
  // only the high argument word starts a search
  assign start_hit = acc_wr && (sel == `ABS_SEL_ARG_HI);

  // ****************************************
  // results word
  // ****************************************
  // flags and address stand until the next search arms
  always_comb begin
    result_word = '0;
    result_word[`ABS_RES_MATCH] = r.match;
    result_word[`ABS_RES_SPARE] = 1'b0;
    result_word[`ABS_RES_ADDR_HI:`ABS_RES_ADDR_LO] = r.probe;
    result_word[`ABS_RES_ABOVE] = r.above;
  end

  // ****************************************
  // tree bottom and steering enable
  // ****************************************
  // odd probes are leaves; a zero start ends at once, so software starts at a power of two
  assign at_bottom = r.probe[0] || (r.probe == '0);
  assign steer_tick = (r.div == DIV_LAST);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = r;
    n.we = '0;
    n.doe = 1'b0;
    n.pend_v = acc;
    n.pend_wr = i_cpu_write_direction;
    n.pend_sel = sel;
    n.div = steer_tick ? '0 : r.div + DIV_ONE;

    // ****************************************
    // selector steering
    // ****************************************
    // updates on the 100-ns enable only, so it trails done by up to four cycles
    if (steer_tick) begin
      n.steer_n = r.done;
    end
    n.tbl_addr = table_pick(r.steer_n, i_cpu_table_address, r.probe);

    // ****************************************
    // processor access, second cycle
    // ****************************************
    if (r.pend_v) begin
      if (r.pend_wr) begin
        if (r.pend_sel == `ABS_SEL_MOVE) begin
          n.arg = i_table_data;
        end
      end else begin
        n.doe = drives_bus(r.pend_sel);
        case (r.pend_sel)
          `ABS_SEL_ARG_LO, `ABS_SEL_ARG_MID, `ABS_SEL_ARG_HI: begin
            n.dout = word_of(r.arg, lane_of(r.pend_sel));
          end
          `ABS_SEL_RESULT: begin
            n.dout = result_word;
          end
          `ABS_SEL_TBL_LO, `ABS_SEL_TBL_MID, `ABS_SEL_TBL_HI: begin
            n.dout = word_of(i_table_data, lane_of(r.pend_sel));
          end
          default: begin
            n.doe = 1'b0;
          end
        endcase
      end
    end

    // ****************************************
    // processor write, first cycle
    // ****************************************
    if (acc_wr) begin
      case (sel)
        `ABS_SEL_ARG_LO, `ABS_SEL_ARG_MID, `ABS_SEL_ARG_HI: begin
          n.arg[`ABS_DW * lane_of(sel) +: `ABS_DW] = i_cpu_data_bus;
        end
        `ABS_SEL_TBL_LO, `ABS_SEL_TBL_MID, `ABS_SEL_TBL_HI: begin
          n.we[lane_of(sel)] = 1'b1;
          n.wdata = i_cpu_data_bus;
        end
        default: begin
        end
      endcase
    end

    // ****************************************
    // search control
    // ****************************************
    case (r.fsm)
      abs_pkg::ABS_IDLE: begin
        if (start_hit) begin
          n.fsm = abs_pkg::ABS_ARM;
        end
      end
      abs_pkg::ABS_ARM: begin
        n.probe = i_search_address_bus;
        n.done = 1'b0;
        n.match = 1'b0;
        n.above = 1'b0;
        n.fsm = abs_pkg::ABS_WAIT;
      end
      abs_pkg::ABS_WAIT: begin
        // table address takes the probe on this edge
        if (!r.steer_n) begin
          n.fsm = abs_pkg::ABS_CMP;
        end
      end
      abs_pkg::ABS_SETTLE: begin
        n.fsm = abs_pkg::ABS_CMP;
      end
      abs_pkg::ABS_CMP: begin
        if (arg_eq) begin
          n.match = 1'b1;
          n.above = 1'b0;
          n.done = 1'b1;
          n.fsm = abs_pkg::ABS_IDLE;
        end else if (at_bottom) begin
          n.match = 1'b0;
          n.above = arg_gt;
          n.done = 1'b1;
          n.fsm = abs_pkg::ABS_IDLE;
        end else begin
          // ascending order makes higher locations hold larger entries
          n.probe = next_probe(r.probe, arg_gt);
          n.fsm = abs_pkg::ABS_SETTLE;
        end
      end
      default: begin
        n.fsm = abs_pkg::ABS_IDLE;
        n.done = 1'b1;
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      r <= RST;
    end else begin
      r <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // processor side
  assign o_cpu_data_bus = r.dout;
  assign o_cpu_data_bus_oe = r.doe;
  // table side
  assign o_table_address = r.tbl_addr;
  assign o_table_wdata = r.wdata;
  assign o_table_lane_we = r.we;
  // status
  assign o_search_done = r.done;
  assign o_probe_select_steer_n = r.steer_n;

endmodule : abs_search_engine

// *** abs_params.svh ***
// constants of the address binary search engine
`ifndef ABS_PARAMS_SVH
`define ABS_PARAMS_SVH

// widths
`define ABS_AW 13
`define ABS_DW 16
`define ABS_KW 48
`define ABS_NIB_W 4
`define ABS_NIBS 12
`define ABS_SLICE_NIBS 4
`define ABS_SLICES 3
`define ABS_LANES 3

// decoder select codes
`define ABS_SEL_MOVE 3'h0
`define ABS_SEL_ARG_LO 3'h1
`define ABS_SEL_ARG_MID 3'h2
`define ABS_SEL_ARG_HI 3'h3
`define ABS_SEL_RESULT 3'h4
`define ABS_SEL_TBL_LO 3'h5
`define ABS_SEL_TBL_MID 3'h6
`define ABS_SEL_TBL_HI 3'h7

// results word layout
`define ABS_RES_MATCH 15
`define ABS_RES_SPARE 14
`define ABS_RES_ADDR_HI 13
`define ABS_RES_ADDR_LO 1
`define ABS_RES_ABOVE 0

// timing
`define ABS_CLK_NS 25
`define ABS_STEER_NS 100
`define ABS_STEER_CYC ((`ABS_STEER_NS + `ABS_CLK_NS - 1) / `ABS_CLK_NS)
`define ABS_DIV_W 2

// reset values
`define ABS_DONE_RST 1'b1
`define ABS_STEER_RST 1'b1

`endif

// *** abs_pkg.sv ***
// types of the address binary search engine
`include "abs_params.svh"

package abs_pkg;

  typedef enum logic [2:0] {
    ABS_IDLE = 3'b000,
    ABS_ARM = 3'b001,
    ABS_WAIT = 3'b010,
    ABS_SETTLE = 3'b011,
    ABS_CMP = 3'b100
  } abs_fsm_t;

  typedef struct packed {
    abs_fsm_t fsm;
    logic done;
    logic steer_n;
    logic [`ABS_DIV_W-1:0] div;
    logic [`ABS_AW-1:0] probe;
    logic [`ABS_AW-1:0] tbl_addr;
    logic [`ABS_KW-1:0] arg;
    logic match;
    logic above;
    logic pend_v;
    logic pend_wr;
    logic [2:0] pend_sel;
    logic [`ABS_DW-1:0] dout;
    logic doe;
    logic [`ABS_LANES-1:0] we;
    logic [`ABS_DW-1:0] wdata;
  } abs_regs_t;

endpackage : abs_pkg

// *** abs_table_ram.sv ***
// address table memory model: 8K entries of 48 bits, async read
`timescale 1ns/100ps
`include "abs_params.svh"
module abs_table_ram (
  // clock
  input wire logic i_sys_clk,
  // table port
  input wire logic [`ABS_AW-1:0] i_addr,
  input wire logic [`ABS_DW-1:0] i_wdata,
  input wire logic [`ABS_LANES-1:0] i_lane_we,
  output logic [`ABS_KW-1:0] o_rdata
);
  logic [`ABS_KW-1:0] mem [0:8191];
  assign o_rdata = mem[i_addr];
  always @(posedge i_sys_clk) begin
    for (int l = 0; l < 3; l++) begin
      if (i_lane_we[l]) begin
        mem[i_addr][l*16 +: 16] <= i_wdata;
      end
    end
  end
endmodule : abs_table_ram

// *** abs_search_engine_asserts.sv ***
// port assertions of the search engine
`timescale 1ns/100ps
`include "abs_params.svh"
module abs_search_engine_asserts (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // processor bus
  input wire logic i_unit_select,
  input wire logic i_cpu_write_direction,
  input wire logic i_xcvr_select_0,
  input wire logic i_xcvr_select_1,
  input wire logic i_xcvr_select_2,
  input wire logic [`ABS_AW-1:0] i_cpu_table_address,
  // outputs watched
  input wire logic [`ABS_DW-1:0] o_cpu_data_bus,
  input wire logic o_cpu_data_bus_oe,
  input wire logic [`ABS_AW-1:0] o_table_address,
  input wire logic [`ABS_LANES-1:0] o_table_lane_we,
  input wire logic o_search_done,
  input wire logic o_probe_select_steer_n
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic [2:0] sel;
  logic take;
  logic rd_take;
  logic wr_take;
  logic arm_r;
  logic [1:0] res_pipe;
  logic res_rd;
  assign sel = {i_xcvr_select_2, i_xcvr_select_1, i_xcvr_select_0};
  // the cycle after the high argument write is the arm cycle, which is refused
  assign take = i_unit_select && o_search_done && o_probe_select_steer_n && !arm_r;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      arm_r <= 1'b0;
      res_pipe <= 2'h0;
    end else begin
      arm_r <= take && i_cpu_write_direction && sel == 3'h3;
      res_pipe <= {res_pipe[0], rd_take && sel == 3'h4};
    end
  end
  assign res_rd = res_pipe[1] && o_cpu_data_bus_oe;
  assign rd_take = take && !i_cpu_write_direction && sel != 3'h0;
  assign wr_take = take && i_cpu_write_direction && sel >= 3'h5;
  sequence s_to_probe;
    ##[0:4] !o_probe_select_steer_n;
  endsequence
  sequence s_to_cpu;
    ##[0:4] o_probe_select_steer_n;
  endsequence
  a_read_answer: assert property (rd_take |-> ##2 o_cpu_data_bus_oe)
    else $error("read gave no data");
  a_oe_cause: assert property (o_cpu_data_bus_oe |-> $past(rd_take, 2))
    else $error("data driven without read");
  a_wr_lane: assert property (wr_take |=> o_table_lane_we == 3'h1 << ($past(sel) - 3'h5))
    else $error("wrong table lane strobe");
  a_busy_quiet: assert property (!o_search_done |-> !o_cpu_data_bus_oe && o_table_lane_we == 3'h0)
    else $error("access during search");
  a_mux_cpu: assert property (o_probe_select_steer_n && $past(o_probe_select_steer_n)
    |-> o_table_address == $past(i_cpu_table_address))
    else $error("selector not on processor");
  a_steer_lag: assert property ($fell(o_search_done) |-> s_to_probe)
    else $error("steer late");
  a_steer_back: assert property ($rose(o_search_done) |-> s_to_cpu)
    else $error("steer not returned");
  a_search_min: assert property ($fell(o_search_done) |-> !o_search_done [*3])
    else $error("search too short");
  a_rst_idle: assert property (@(posedge i_sys_clk) disable iff (1'b0)
    i_rst |=> o_search_done && o_probe_select_steer_n && !o_cpu_data_bus_oe)
    else $error("reset state wrong");
  a_spare_zero: assert property (res_rd |-> !o_cpu_data_bus[14])
    else $error("results spare bit set");
  a_hit_clean: assert property (res_rd && o_cpu_data_bus[15] |-> !o_cpu_data_bus[0])
    else $error("above flag set on a match");
  a_miss_bottom: assert property (res_rd && !o_cpu_data_bus[15] |->
    o_cpu_data_bus[1] || o_cpu_data_bus[13:1] == 13'h0)
    else $error("miss ended above the tree bottom");
endmodule : abs_search_engine_asserts
bind abs_search_engine abs_search_engine_asserts u_chk (.*);

// *** address_table_binary_search_test.sv ***
// self-checking bench of the search engine against an integer model
`timescale 1ns/100ps
`include "abs_params.svh"
module address_table_binary_search_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic us = 1'b0;
  logic wr = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [12:0] ca = 13'h0;
  logic [15:0] cd = 16'h0;
  logic [12:0] sa = 13'h1000;
  logic [15:0] rd;
  logic oe;
  logic [12:0] ta;
  logic [47:0] td;
  logic [15:0] tw;
  logic [2:0] twe;
  logic done;
  logic steer_n;
  logic [47:0] k;
  integer n_mismatch = 0;
  integer n_tests = 0;
  integer seed = 34626;
  always #12.5 clk = ~clk;
  abs_search_engine dut (.i_sys_clk(clk), .i_rst(rst), .i_unit_select(us), .i_cpu_write_direction(wr),
    .i_xcvr_select_0(sel[0]), .i_xcvr_select_1(sel[1]), .i_xcvr_select_2(sel[2]), .i_cpu_table_address(ca),
    .i_cpu_data_bus(cd), .o_cpu_data_bus(rd), .o_cpu_data_bus_oe(oe), .i_search_address_bus(sa),
    .o_table_address(ta), .i_table_data(td), .o_table_wdata(tw), .o_table_lane_we(twe),
    .o_search_done(done), .o_probe_select_steer_n(steer_n));
  abs_table_ram u_ram (.i_sys_clk(clk), .i_addr(ta), .i_wdata(tw), .i_lane_we(twe), .o_rdata(td));
  function automatic logic [47:0] key(input integer i);
    key = 48'(i) * 48'h4;
  endfunction : key
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : finish_test
  task automatic bus(input logic w, input logic [2:0] s, input logic [12:0] a, input logic [15:0] d);
    @(negedge clk);
    us = 1'b1;
    wr = w;
    sel = s;
    ca = a;
    cd = d;
    @(negedge clk);
    us = 1'b0;
  endtask : bus
  task automatic rdw(input string nm, input logic [2:0] s, input logic [12:0] a, input logic [15:0] exp);
    bus(1'b0, s, a, 16'h0);
    @(negedge clk);
    chk("oe", {15'h0, oe}, 16'h1);
    chk(nm, rd, exp);
  endtask : rdw
  task automatic reset();
    rst = 1'b1;
    ca = 13'h0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
  endtask : reset
  task automatic search(input logic [47:0] arg);
    integer p;
    integer st;
    integer i;
    logic m;
    logic ab;
    p = sa;
    for (int j = 0; j < 14; j++) begin
      m = arg == key(p);
      ab = arg > key(p);
      if (m || p[0] || p == 0) break;
      st = (p & -p) / 2;
      p = ab ? p + st : p - st;
    end
    bus(1'b1, 3'h1, 13'h0, arg[15:0]);
    bus(1'b1, 3'h2, 13'h0, arg[31:16]);
    bus(1'b1, 3'h3, 13'h0, arg[47:32]);
    @(negedge clk);
    chk("busy", {15'h0, done}, 16'h0);
    bus(1'b1, 3'h5, 13'h5, 16'hdead);
    for (i = 0; i < 100 && !(done === 1'b1 && steer_n === 1'b1); i++) @(negedge clk);
    if (i == 100) begin
      n_mismatch++;
      finish_test();
    end
    rdw("result", 3'h4, 13'h0, {m, 1'b0, 13'(p), ab & !m});
  endtask : search
  initial begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
  initial begin
    reset();
    chk("idle", {14'h0, done, steer_n}, 16'h3);
    rdw("result", 3'h4, 13'h0, 16'h0);
    for (int a = 0; a < 8192; a++) begin
      k = key(a);
      bus(1'b1, 3'h5, 13'(a), k[15:0]);
      bus(1'b1, 3'h6, 13'(a), k[31:16]);
      bus(1'b1, 3'h7, 13'(a), k[47:32]);
    end
    k = key(419);
    for (int s = 5; s < 8; s++) rdw("table", 3'(s), 13'h1a3, k[(s-5)*16 +: 16]);
    bus(1'b1, 3'h0, 13'h0ff, 16'h0);
    k = key(255);
    for (int s = 1; s < 4; s++) rdw("move", 3'(s), 13'h0, k[(s-1)*16 +: 16]);
    search(key(0));
    search(key(8191) + 48'h1);
    search(key(4096));
    sa = 13'h0400;
    search(key(600) + 48'h2);
    sa = 13'h1000;
    for (int n = 0; n < 20; n++) begin
      search(key($random(seed) & 16'h1fff) + 48'($random(seed) & 3));
    end
    k = key(5);
    rdw("table", 3'h5, 13'h5, k[15:0]);
    reset();
    rdw("result", 3'h4, 13'h0, 16'h0);
    search(key(77) + 48'h3);
    finish_test();
  end
endmodule : address_table_binary_search_test
